// >>> remote_upgrade_control.sv
/*
 * Remote upgrade control: APB register file holding the 39-bit control
 * word, a load sequencer that checks and launches the application image
 * or falls back to the factory image, the user watchdog, and a sticky
 * reconfiguration-cause status register with masked interrupt.
 * Assumes APB master in the same clock domain; pin inputs synchronous.
 */
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module remote_upgrade_control
    import upgrade_pkg::*;
(
    input  wire logic        clk_i,                 // 50 MHz clock
    input  wire logic        rst_n_i,               // async reset, low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb enable
    input  wire logic        pwrite,                // apb write
    input  wire logic [7:0]  paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    output logic [31:0]      prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error
    input  wire logic        config_complete_pin_i, // load completed
    input  wire logic        config_fault_line_i,   // external fault, low
    input  wire logic        crc_error_i,           // crc error pulse
    input  wire logic        img_valid_i,           // image header valid
    input  wire logic [23:0] img_size_i,            // image size found
    input  wire logic [23:0] exp_size_i,            // expected image size
    output logic             load_start_o,          // begin image load
    output logic [23:0]      load_addr_o,           // boot address
    output logic             osc_select_o,          // internal osc clock
    output logic             factory_reload_o,      // reload factory
    output logic             irq_o                  // interrupt, high
);
    logic [CW_WIDTH-1:0] cw;
    logic [ST_WIDTH-1:0] status;
    logic [ST_WIDTH-1:0] mask;
    logic [ST_WIDTH-1:0] next_events;
    logic                fault_q;
    logic                wr_en;
    logic                rd_en;
    logic                addr_ok;
    logic                wd_kick;
    logic                wd_expire;
    logic                chk_start;
    logic                chk_done;
    logic                chk_good;
    logic [7:0]          early_cnt;
    logic                user_reconf;
    logic                start_req;
    load_state_t         state;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    always_comb begin
        if (paddr == CW_LO_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == CW_HI_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == STATUS_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == MASK_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == CTRL_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == STATE_ADDR) begin
            addr_ok = 1'b1;
        end else if (paddr == BOOT_ADDR) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // zero-wait slave: answer in the first access cycle
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    logic acc;
    assign acc = psel && penable && pready;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == CW_LO_ADDR) begin
                prdata <= cw[31:0];
            end else if (paddr == CW_HI_ADDR) begin
                prdata <= {25'h0000000, cw[CW_WIDTH-1:32]};
            end else if (paddr == STATUS_ADDR) begin
                prdata <= {25'h0000000, status};
            end else if (paddr == MASK_ADDR) begin
                prdata <= {25'h0000000, mask};
            end else if (paddr == STATE_ADDR) begin
                prdata <= {29'h00000000, 3'(state)};
            end else if (paddr == BOOT_ADDR) begin
                prdata <= {8'h00, boot_addr(cw)};
            end else begin
                prdata <= '0;
            end
        end
    end

    // control word; reserved bits hold their reset values
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cw <= CW_RESET;
        end else if (acc && wr_en && paddr == CW_LO_ADDR) begin
            cw[31:0] <= pwdata;
        end else if (acc && wr_en && paddr == CW_HI_ADDR) begin
            cw[CW_WIDTH-1:32] <= (pwdata[6:0] & CW_WRITABLE[38:32])
                | (cw[CW_WIDTH-1:32] & ~CW_WRITABLE[38:32]);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mask <= '0;
        end else if (acc && wr_en && paddr == MASK_ADDR) begin
            mask <= pwdata[ST_WIDTH-1:0];
        end
    end

    // control strobes are one-cycle pulses from a write
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_req   <= 1'b0;
            user_reconf <= 1'b0;
            wd_kick     <= 1'b0;
        end else begin
            start_req   <= acc && wr_en && paddr == CTRL_ADDR
                && pwdata[CTL_START];
            user_reconf <= acc && wr_en && paddr == CTRL_ADDR
                && pwdata[CTL_RECONF];
            wd_kick     <= acc && wr_en && paddr == CTRL_ADDR
                && pwdata[CTL_WD_KICK];
        end
    end

    // fault line edge: previous level registered, line itself synchronous
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_q <= 1'b1;
        end else begin
            fault_q <= config_fault_line_i;
        end
    end

    upgrade_watchdog u_wdog (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .run_i    (cw[WATCHDOG_ENABLE_BIT_BIT] && state == LD_USER),
        .kick_i   (wd_kick),
        .load_i   (wd_count(cw)),
        .expire_o (wd_expire)
    );

    upgrade_image_check u_check (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .start_i     (chk_start),
        .img_valid_i (img_valid_i),
        .img_size_i  (img_size_i),
        .exp_size_i  (exp_size_i),
        .done_o      (chk_done),
        .good_o      (chk_good)
    );

    assign chk_start = state == LD_IDLE && start_req && cw[EARLY_BIT];

    // load sequencer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state     <= LD_IDLE;
            early_cnt <= '0;
        end else begin
            case (state)
                LD_IDLE: begin
                    early_cnt <= '0;
                    if (start_req) begin
                        state <= cw[EARLY_BIT] ? LD_CHECK : LD_LOAD;
                    end
                end
                LD_CHECK: begin
                    if (chk_done) begin
                        state <= chk_good ? LD_LOAD : LD_FACTORY;
                    end
                end
                LD_LOAD: begin
                    if (early_cnt != EARLY_CYC_W) begin
                        early_cnt <= early_cnt + 8'h01;
                    end
                    if (!config_fault_line_i || crc_error_i) begin
                        state <= LD_FACTORY;
                    end else if (config_complete_pin_i) begin
                        // too-early completion means a truncated image
                        if (cw[EARLY_BIT] && early_cnt != EARLY_CYC_W) begin
                            state <= LD_FACTORY;
                        end else begin
                            state <= LD_USER;
                        end
                    end
                end
                LD_USER: begin
                    if (wd_expire || user_reconf || !config_fault_line_i) begin
                        state <= LD_FACTORY;
                    end
                end
                LD_FACTORY: begin
                    state <= LD_IDLE;
                end
                default: begin
                    state <= LD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_start_o     <= 1'b0;
            load_addr_o      <= '0;
            osc_select_o     <= 1'b0;
            factory_reload_o <= 1'b0;
        end else begin
            load_start_o     <= (state == LD_IDLE && start_req
                                 && !cw[EARLY_BIT])
                                || (state == LD_CHECK && chk_done
                                    && chk_good);
            load_addr_o      <= boot_addr(cw);
            osc_select_o     <= cw[OSC_BIT];
            factory_reload_o <= state == LD_FACTORY;
        end
    end

    // cause events for the status register
    always_comb begin
        next_events = '0;
        next_events[ST_CRC]    = crc_error_i && state == LD_LOAD;
        next_events[ST_FAULT]  = fault_q && !config_fault_line_i;
        next_events[ST_USER]   = user_reconf && state == LD_USER;
        next_events[ST_WDOG]   = wd_expire && state == LD_USER;
        next_events[ST_EARLY]  = state == LD_LOAD && config_complete_pin_i
            && cw[EARLY_BIT] && early_cnt != EARLY_CYC_W;
        next_events[ST_BADIMG] = state == LD_CHECK && chk_done && !chk_good;
        next_events[ST_LOADED] = state == LD_LOAD && config_complete_pin_i;
    end

    // write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status <= '0;
        end else if (acc && wr_en && paddr == STATUS_ADDR) begin
            status <= (status & ~pwdata[ST_WIDTH-1:0]) | next_events;
        end else begin
            status <= status | next_events;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end
endmodule
`default_nettype wire

// >>> remote_upgrade_control_properties.sv
/* Port checker for remote_upgrade_control, bound onto the top.
   Assumes one clock domain and the APB timing of the hand-over. */
`timescale 1ns/1ps
`default_nettype none
module remote_upgrade_control_properties
    import upgrade_pkg::*;
(
    input wire logic        clk_i,           // clock
    input wire logic        rst_n_i,         // reset
    input wire logic        psel,            // select
    input wire logic        penable,         // enable
    input wire logic        pwrite,          // write
    input wire logic [7:0]  paddr,           // address
    input wire logic [31:0] pwdata,          // write data
    input wire logic        pready,          // ready
    input wire logic        pslverr,         // error
    input wire logic        load_start_o,    // load pulse
    input wire logic [23:0] load_addr_o,     // boot address
    input wire logic        osc_select_o,    // osc select
    input wire logic        factory_reload_o // reload pulse
);
    logic wr_hi;
    logic hi_wr;
    logic osc_want;
    logic [21:0] page_want;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    assign wr_hi = psel && penable && pready && pwrite && paddr == CW_HI_ADDR;
    // keep the written bit: pwdata may move on after the access
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_wr <= 1'b0;
            osc_want <= 1'b0;
            page_want <= '0;
        end else begin
            hi_wr <= wr_hi;
            if (wr_hi) begin
                osc_want <= pwdata[OSC_BIT-32];
                page_want[21:20] <= pwdata[1:0];
            end
            if (psel && penable && pready && pwrite && paddr == CW_LO_ADDR) begin
                page_want[19:0] <= pwdata[31:12];
            end
        end
    end
    setup_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    start_pulse_a: assert property (load_start_o |=> !load_start_o)
        else $error("load start too long");
    reload_pulse_a: assert property (
        factory_reload_o |=> !factory_reload_o)
        else $error("reload too long");
    boot_addr_a: assert property (
        load_start_o |-> load_addr_o == {page_want, 2'b00})
        else $error("boot address not from written page");
    osc_follow_a: assert property (
        hi_wr |-> ##[0:1] osc_select_o == osc_want)
        else $error("oscillator select does not follow");
    one_action_a: assert property (
        !(load_start_o && factory_reload_o))
        else $error("load and reload together");
endmodule
bind remote_upgrade_control remote_upgrade_control_properties u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .load_start_o(load_start_o),
    .load_addr_o(load_addr_o), .osc_select_o(osc_select_o),
    .factory_reload_o(factory_reload_o));
`default_nettype wire

// >>> test_remote_upgrade_control.sv
/* Self-checking bench for remote_upgrade_control.
   Assumes the far-side model and checker files are compiled before. */
`timescale 1ns/1ps
`default_nettype none
module test_remote_upgrade_control;
    import upgrade_pkg::*;
    localparam logic [23:0] SIZE = 24'h001000;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        crc_err = 1'b0;
    logic        fault_n = 1'b1;
    logic [7:0]  delay = 8'h00;
    logic        bad = 1'b0;
    logic        valid = 1'b1;
    logic [31:0] prdata;
    logic        pready, pslverr, done, start, osc, reload, irq;
    logic        last_err, done_q;
    logic [23:0] size, addr, got_addr;
    int          miscompares = 0, checks = 0, n_start = 0, n_reload = 0;
    int          cyc = 0, t_done = 0, t_reload = 0;
    always #10 clk_i = ~clk_i;
    remote_upgrade_control DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .config_complete_pin_i(done),
        .config_fault_line_i(fault_n), .crc_error_i(crc_err),
        .img_valid_i(valid), .img_size_i(size), .exp_size_i(SIZE),
        .load_start_o(start), .load_addr_o(addr), .osc_select_o(osc),
        .factory_reload_o(reload), .irq_o(irq));
    upgrade_user_model #(.IMG_SIZE(SIZE)) far_side (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .start_i(start), .abort_i(reload),
        .delay_i(delay), .bad_i(bad), .done_o(done), .size_o(size));
    always @(posedge clk_i) begin
        if (start) begin
            n_start++;
            got_addr = addr;
        end
        if (reload) begin
            n_reload++;
            t_reload = cyc;
        end
        if (done && !done_q) t_done = cyc;
        done_q = done;
        cyc++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) chk(pready, 32'h1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    task automatic wait_ev(ref int c);
        int n;
        n = 0;
        while (c == 0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk(c != 0, 1);
    endtask
    // second reset mid-run also puts the sequencer back to idle
    task automatic restart();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        n_start = 0;
        n_reload = 0;
    endtask
    task automatic launch(input logic [31:0] hi, input logic [31:0] lo,
                          input logic [7:0] d, input logic b);
        delay <= d;
        bad <= b;
        wr(CW_LO_ADDR, lo);
        wr(CW_HI_ADDR, hi);
        wr(CTRL_ADDR, 32'h1);
    endtask
    task automatic t_regs();
        rd(CW_LO_ADDR, 32'hFFFFFFFF, 32'h0);
        rd(CW_HI_ADDR, 32'hFFFFFFFF, 32'h78);
        chk(osc, 1);
        wr(CW_LO_ADDR, 32'hABCDE123);
        wr(CW_HI_ADDR, 32'h7F);
        rd(CW_LO_ADDR, 32'hFFFFFFFF, 32'hABCDE123);
        rd(CW_HI_ADDR, 32'hFFFFFFFF, 32'h7B);
        rd(BOOT_ADDR, 32'hFFFFFFFF, 32'h00EAF378);
        wr(CW_HI_ADDR, 32'h0);
        rd(CW_HI_ADDR, 32'hFFFFFFFF, 32'h40);
        chk(osc, 0);
        rd(8'h1C, 32'hFFFFFFFF, 32'h0);
        chk(last_err, 1);
        $display("registers done");
    endtask
    task automatic t_load_ok();
        restart();
        launch(32'h33, 32'hABCDE000, 8'h28, 1'b0);
        wait_ev(n_start);
        chk(n_start, 1);
        chk(got_addr, 24'hEAF378);
        repeat (80) @(posedge clk_i);
        chk(n_reload, 0);
        rd(STATE_ADDR, 32'hFFFFFFFF, 32'h3);
        rd(STATUS_ADDR, 32'h78, 32'h40);
        wr(CTRL_ADDR, 32'h2);
        repeat (4) @(posedge clk_i);
        rd(STATUS_ADDR, 32'h4, 32'h4);
        $display("good load done");
    endtask
    task automatic t_early();
        restart();
        wr(MASK_ADDR, 32'h10);
        launch(32'h30, 32'h0, 8'h03, 1'b0);
        wait_ev(n_reload);
        chk(n_reload, 1);
        rd(STATUS_ADDR, 32'h30, 32'h10);
        chk(irq, 1);
        wr(STATUS_ADDR, 32'h10);
        rd(STATUS_ADDR, 32'h10, 32'h0);
        chk(irq, 0);
        rd(MASK_ADDR, 32'hFFFFFFFF, 32'h10);
        restart();
        launch(32'h30, 32'h0, 8'h28, 1'b1);
        wait_ev(n_reload);
        chk(n_start, 0);
        rd(STATUS_ADDR, 32'h20, 32'h20);
        // header missing altogether, size still right
        restart();
        valid <= 1'b0;
        launch(32'h30, 32'h0, 8'h28, 1'b0);
        wait_ev(n_reload);
        valid <= 1'b1;
        chk(n_start, 0);
        rd(STATUS_ADDR, 32'h20, 32'h20);
        $display("early and bad image done");
    endtask
    task automatic t_watchdog();
        restart();
        launch(32'h38, 32'h0, 8'h28, 1'b0);
        wait_ev(n_reload);
        chk(t_reload - t_done >= 8 && t_reload - t_done <= 16, 1);
        rd(STATUS_ADDR, 32'h08, 32'h08);
        $display("watchdog done");
    endtask
    task automatic t_faults();
        restart();
        wr(MASK_ADDR, 32'h01);
        launch(32'h30, 32'h0, 8'hC8, 1'b0);
        wait_ev(n_start);
        crc_err <= 1'b1;
        @(posedge clk_i);
        crc_err <= 1'b0;
        fault_n <= 1'b0;
        repeat (3) @(posedge clk_i);
        fault_n <= 1'b1;
        chk(irq, 1);
        rd(STATUS_ADDR, 32'h03, 32'h03);
        wr(STATUS_ADDR, 32'h01);
        rd(STATUS_ADDR, 32'h03, 32'h02);
        chk(irq, 0);
        $display("fault causes done");
    endtask
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_load_ok();
        t_early();
        t_watchdog();
        t_faults();
        stop_test();
    end
    initial begin
        #400000;
        miscompares++;
        stop_test();
    end
endmodule
`default_nettype wire

// >>> upgrade_image_check.sv
/*
 * Image checker: on a start pulse, looks at the image size reported for
 * the boot address and flags whether the header is valid and the size matches the expected size.
 * Assumes the storage side presents size and valid as steady levels.
 */
`timescale 1ns/1ps
`default_nettype none
module upgrade_image_check
    import upgrade_pkg::*;
(
    input  wire logic        clk_i,        // clock
    input  wire logic        rst_n_i,      // async reset, low
    input  wire logic        start_i,      // begin check pulse
    input  wire logic        img_valid_i,  // header found at address
    input  wire logic [23:0] img_size_i,   // size found in header
    input  wire logic [23:0] exp_size_i,   // expected size
    output logic             done_o,       // one-cycle result strobe
    output logic             good_o        // image acceptable
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
            good_o <= 1'b0;
        end else begin
            done_o <= start_i;
            if (start_i) begin
                good_o <= img_valid_i && (img_size_i == exp_size_i);
            end
        end
    end
endmodule
`default_nettype wire

// >>> upgrade_pkg.sv
/*
 * Constants for the remote upgrade control block: register offsets,
 * control word field layout, reset values, status bits, load timing.
 * Assumes a single 50 MHz clock domain and an APB register master.
 */
// What this block does
// - watchdog count is 29 bits: timeout field on top, then 17'b1000
// - boot address is 24 bits: address field on top, two zero bits below
// - timeout in bits 11..0, address in 33..12; bits 34 and 38 reserved
// - bit 35 enables the user watchdog; it runs only when set
// - bit 36 selects internal oscillator as startup clock
// - bit 37 checks a valid, properly sized image exists at boot address
// - with check on, bad image or early completion reloads factory image
// - status register records cause of each reconfiguration
package upgrade_pkg;
    localparam int CW_WIDTH = 39;
    localparam int TMO_LSB = 0;
    localparam int TMO_MSB = 11;
    localparam int ADDR_LSB = 12;
    localparam int ADDR_MSB = 33;
    localparam int RSV_LO_BIT = 34;
    localparam int WATCHDOG_ENABLE_BIT_BIT = 35;
    localparam int OSC_BIT = 36;
    localparam int EARLY_BIT = 37;
    localparam int RSV_HI_BIT = 38;
    localparam int WD_CNT_WIDTH = 29;
    localparam logic [16:0] WD_LOW_BITS = 17'h00008;
    localparam int BOOT_WIDTH = 24;
    localparam logic [CW_WIDTH-1:0] CW_RESET = 39'h7800000000;
    localparam logic [CW_WIDTH-1:0] CW_WRITABLE = 39'h3BFFFFFFFF;

    // register byte addresses
    localparam logic [7:0] CW_LO_ADDR = 8'h00;
    localparam logic [7:0] CW_HI_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] MASK_ADDR = 8'h0C;
    localparam logic [7:0] CTRL_ADDR = 8'h10;
    localparam logic [7:0] STATE_ADDR = 8'h14;
    localparam logic [7:0] BOOT_ADDR = 8'h18;

    // status bit positions
    localparam int ST_CRC = 0;
    localparam int ST_FAULT = 1;
    localparam int ST_USER = 2;
    localparam int ST_WDOG = 3;
    localparam int ST_EARLY = 4;
    localparam int ST_BADIMG = 5;
    localparam int ST_LOADED = 6;
    localparam int ST_WIDTH = 7;

    // control register bits
    localparam int CTL_START = 0;
    localparam int CTL_RECONF = 1;
    localparam int CTL_WD_KICK = 2;

    // minimum load time before completion counts as genuine
    localparam int EARLY_NS = 200;
    localparam int CLK_NS = 20;
    localparam int EARLY_CYC = (EARLY_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] EARLY_CYC_W = 8'(EARLY_CYC);

    typedef enum logic [2:0] {
        LD_IDLE,
        LD_CHECK,
        LD_LOAD,
        LD_USER,
        LD_FACTORY
    } load_state_t;

    function automatic logic [WD_CNT_WIDTH-1:0] wd_count(
        input logic [CW_WIDTH-1:0] cw
    );
        wd_count = {cw[TMO_MSB:TMO_LSB], WD_LOW_BITS};
    endfunction

    function automatic logic [BOOT_WIDTH-1:0] boot_addr(
        input logic [CW_WIDTH-1:0] cw
    );
        boot_addr = {cw[ADDR_MSB:ADDR_LSB], 2'b00};
    endfunction
endpackage

// >>> upgrade_user_model.sv
/* Far-side model: image storage and the loader behind it.
   Assumes load start and reload arrive as one-cycle pulses. */
`timescale 1ns/1ps
`default_nettype none
module upgrade_user_model #(
    parameter logic [23:0] IMG_SIZE = 24'h001000 // plain default
) (
    input  wire logic        clk_i,      // clock
    input  wire logic        rst_n_i,    // reset
    input  wire logic        start_i,    // begin load
    input  wire logic        abort_i,    // factory reload
    input  wire logic [7:0]  delay_i,    // load length
    input  wire logic        bad_i,      // wrong size
    output logic             done_o,     // load complete
    output logic [23:0]      size_o      // header size
);
    logic [7:0] left;
    logic       busy;
    // a bad image is a size mismatch, header still present
    assign size_o = bad_i ? IMG_SIZE + 24'h000001 : IMG_SIZE;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy <= 1'b0;
            left <= 8'h00;
            done_o <= 1'b0;
        end else if (start_i) begin
            busy <= 1'b1;
            left <= delay_i;
            done_o <= 1'b0;
        end else if (abort_i) begin
            busy <= 1'b0;
            done_o <= 1'b0;
        end else if (busy && left == 8'h00) begin
            busy <= 1'b0;
            done_o <= 1'b1;
        end else if (busy) begin
            left <= left - 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> upgrade_watchdog.sv
/*
 * User watchdog: counts down from the loaded timeout while enabled.
 * Assumes the enable and timeout come from the control word owner.
 */
`timescale 1ns/1ps
`default_nettype none
module upgrade_watchdog
    import upgrade_pkg::*;
(
    input  wire logic                    clk_i,     // clock
    input  wire logic                    rst_n_i,   // async reset, low
    input  wire logic                    run_i,     // watchdog enabled
    input  wire logic                    kick_i,    // reload pulse
    input  wire logic [WD_CNT_WIDTH-1:0] load_i,    // timeout count
    output logic                         expire_o   // one-cycle expiry
);
    logic [WD_CNT_WIDTH-1:0] count;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count    <= '0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (!run_i || kick_i) begin
                count <= load_i;
            end else if (count == '0) begin
                expire_o <= 1'b1;
                count    <= load_i;
            end else begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire
